// [logic/sdmc_pkg.sv]
// Constants, field layouts and carrier types for the SDRAM configuration block.
// Assumes every pin is sampled on the rising edge of the block clock.
package sdmc_pkg;

  // ****************************************************************
  // Pin widths and layout
  // ****************************************************************
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned BANK_W     = 2;
  localparam int unsigned COL_W      = 9;
  localparam int unsigned MODE_W     = 10;
  localparam int unsigned EXT_W      = 7;
  localparam int unsigned PIN_W      = 20;
  localparam int unsigned BEAT_W     = 4;
  localparam int unsigned OHM_W      = 7;

  // ****************************************************************
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ****************************************************************
  localparam logic [3:0] CMD_CONFIG_LOAD = 4'h0;
  localparam logic [3:0] CMD_READ        = 4'h5;
  localparam logic [3:0] CMD_WRITE       = 4'h4;
  localparam logic [3:0] CMD_BURST_STOP  = 4'h6;

  // Bank-select targets of the configuration load
  localparam logic [1:0] BANK_SEL_MODE   = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT    = 2'h2;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [2:0] BURST_LEN_1     = 3'h0;
  localparam logic [2:0] BURST_LEN_2     = 3'h1;
  localparam logic [2:0] BURST_LEN_4     = 3'h2;
  localparam logic [2:0] BURST_LEN_8     = 3'h3;
  localparam logic [2:0] BURST_LEN_PAGE  = 3'h7;
  localparam logic [2:0] LATENCY_2       = 3'h2;
  localparam logic [2:0] LATENCY_3       = 3'h3;
  localparam logic [1:0] OP_MODE_NORMAL  = 2'h0;
  localparam logic       ORDER_SEQ       = 1'b0;

  localparam logic [2:0] PARTIAL_FULL    = 3'h0;
  localparam logic [2:0] PARTIAL_HALF    = 3'h1;
  localparam logic [2:0] PARTIAL_QUARTER = 3'h2;
  localparam logic [2:0] PARTIAL_EIGHTH  = 3'h5;
  localparam logic [2:0] PARTIAL_SIXTNTH = 3'h6;
  localparam logic [3:0] BANKS_ALL       = 4'hf;
  localparam logic [3:0] BANKS_01        = 4'h3;
  localparam logic [3:0] BANKS_0         = 4'h1;

  localparam logic [1:0] DRIVE_FULL      = 2'h0;
  localparam logic [1:0] DRIVE_HALF      = 2'h1;
  localparam logic [1:0] DRIVE_QUARTER   = 2'h2;
  localparam logic [1:0] DRIVE_THREE_Q   = 2'h3;
  localparam logic [6:0] OHMS_FULL       = 7'h19;
  localparam logic [6:0] OHMS_THREE_Q    = 7'h25;
  localparam logic [6:0] OHMS_HALF       = 7'h37;
  localparam logic [6:0] OHMS_QUARTER    = 7'h50;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       single_write_bit;
    logic [1:0] op_mode;
    logic [2:0] read_latency;
    logic       burst_order_bit;
    logic [2:0] burst_len;
  } sdmc_mode_t;

  typedef struct packed {
    logic [1:0] drive_strength;
    logic [1:0] temp_comp_refresh_field;
    logic [2:0] partial_refresh_field;
  } sdmc_ext_t;

  typedef struct packed {
    logic              cke;
    logic [3:0]        cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdmc_pins_t;

  typedef struct packed {
    logic [3:0] bank_mask;
    logic [1:0] row_top_zero;
  } sdmc_refresh_t;

endpackage

// [logic/sdmc_core.sv]
// Configuration registers, burst column sequencer and read-latency timing
// of a low-power SDR SDRAM. Assumes the controller drives the command and
// address pins; each pin passes a two-flop synchroniser before use.
//
// Behaviour
// [RQ1] Mode word fields decoded at documented bit positions
// [RQ2] Controller zeroes upper mode bits and bank-select
// [RQ3] Controller loads only when idle, then waits
// [RQ4] Mode word held until next load
// [RQ5] Lengths 1,2,4,8 both types, page sequential
// [RQ6] Fixed burst block from upper column bits
// [RQ7] Sequential order increments modulo length in block
// [RQ8] Interleaved offset is start XOR beat count
// [RQ9] Page burst wraps to column zero until stopped
// [RQ10] Read latency two or three cycles only
// [RQ11] Drive from n+m-1, data valid n+m
// [RQ12] Controller programs operating mode to zero
// [RQ13] Single write bit makes writes one location
// [RQ14] Bank-select 10 loads extended register
// [RQ15] Controller zeroes extended upper bits, loads idle
// [RQ16] Extended register survives deep sleep
// [RQ17] Temperature-compensation field writes ignored
// [RQ18] Partial refresh limits self-refresh to five scopes
// [RQ19] Partial refresh never restricts reads or writes
// [RQ20] Four drive impedances: 25,37,55,80 ohms
// [RQ21] Controller issues only no-ops while settling
// [RQ22] Controller loads mode word before operation
// [RQ23] Customary length and latency encodings used
// [RQ24] Reserved codes flag a configuration error

`timescale 1ns/10ps

module sdmc_core
  import sdmc_pkg::*;
(
  input  wire logic                        clk,             // 40 MHz clock
  input  wire logic                        resetn,          // Async reset
  input  wire logic                        cke,             // Clock enable pin
  input  wire logic                        cs_n,            // Chip select
  input  wire logic                        ras_n,           // Row strobe
  input  wire logic                        cas_n,           // Column strobe
  input  wire logic                        we_n,            // Write enable
  input  wire logic [sdmc_pkg::BANK_W-1:0] ba,              // Bank select
  input  wire logic [sdmc_pkg::ADDR_W-1:0] addr,            // Address pins
  output sdmc_pkg::sdmc_mode_t             mode_cfg,        // Stored mode word
  output sdmc_pkg::sdmc_ext_t              ext_cfg,         // Stored extended word
  output logic                             mode_loaded,     // Mode word loaded once
  output logic                             config_error,    // Reserved code loaded
  output sdmc_pkg::sdmc_refresh_t          refresh_scope,   // Self-refresh scope
  output logic [sdmc_pkg::OHM_W-1:0]       drive_ohms,      // Driver impedance
  output logic                             burst_active,    // Beat on burst_col
  output logic                             burst_is_write,  // Beat is a write
  output logic [sdmc_pkg::COL_W-1:0]       burst_col,       // Beat column
  output logic                             dq_drive_en,     // Data pins driven
  output logic                             dq_data_valid,   // Read word valid
  output logic                             deep_sleep_state // Deep sleep entered
);
  import sdmc_pkg::*;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  sdmc_pins_t       pins_raw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  sdmc_pins_t       pins;

  assign pins_raw = '{cke: cke, cmd: {cs_n, ras_n, cas_n, we_n}, ba: ba, addr: addr};
  assign pins     = sdmc_pins_t'(sync2_q);

  // Command bits reset to the load code; cke resets low,
  // so the decoder ignores them until cke is seen high twice
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic cke_prev_q;
  logic deep_q;
  logic run_q;

  // Commands act only while cke is high now and at the last sample;
  // a burst stop with cke falling and no burst running enters deep sleep instead
  wire cmd_enabled   = pins.cke && cke_prev_q && !deep_q;
  wire cmd_load      = cmd_enabled && (pins.cmd == CMD_CONFIG_LOAD);
  wire load_mode     = cmd_load && (pins.ba == BANK_SEL_MODE);
  wire load_ext      = cmd_load && (pins.ba == BANK_SEL_EXT);   // RQ14
  wire cmd_read      = cmd_enabled && (pins.cmd == CMD_READ);
  wire cmd_write     = cmd_enabled && (pins.cmd == CMD_WRITE);
  wire cmd_access    = cmd_read || cmd_write;
  wire cmd_stop      = cmd_enabled && (pins.cmd == CMD_BURST_STOP);
  wire sleep_entry   = cke_prev_q && !pins.cke && !deep_q && !run_q
                       && (pins.cmd == CMD_BURST_STOP);
  wire sleep_exit    = deep_q && pins.cke;

  // ****************************************************************
  // Configuration storage
  // ****************************************************************
  sdmc_mode_t    mode_q;
  sdmc_ext_t     ext_q;
  sdmc_mode_t    mode_in;
  sdmc_ext_t     ext_in;
  sdmc_refresh_t scope_d;
  sdmc_refresh_t scope_q;
  logic [OHM_W-1:0] ohms_d;
  logic [OHM_W-1:0] ohms_q;
  logic          loaded_q;
  logic          error_q;

  // Reserved codes still load; they run as length one or latency two
  // and only raise the error flag
  assign mode_in = sdmc_mode_t'(pins.addr[MODE_W-1:0]);                 // RQ1
  // Temperature field kept at zero; the on-chip sensor sets the rate
  assign ext_in  = '{drive_strength:          pins.addr[6:5],
                     temp_comp_refresh_field: 2'h0,                     // RQ17
                     partial_refresh_field:   pins.addr[2:0]};

  wire len_ok   = (mode_in.burst_len == BURST_LEN_1) || (mode_in.burst_len == BURST_LEN_2)
                  || (mode_in.burst_len == BURST_LEN_4) || (mode_in.burst_len == BURST_LEN_8)
                  || (mode_in.burst_len == BURST_LEN_PAGE);                // RQ23
  wire page_bad = (mode_in.burst_len == BURST_LEN_PAGE)
                  && (mode_in.burst_order_bit != ORDER_SEQ);                 // RQ5
  wire lat_ok   = (mode_in.read_latency == LATENCY_2)
                  || (mode_in.read_latency == LATENCY_3);                   // RQ10
  wire mode_bad = !len_ok || page_bad || !lat_ok
                  || (mode_in.op_mode != OP_MODE_NORMAL)                    // RQ12
                  || (pins.addr[ADDR_W-1:MODE_W] != '0);                    // RQ2

  // Scope and impedance decoded at load time so outputs stay registered
  always_comb begin
    case (ext_in.partial_refresh_field)                                    // RQ18
      PARTIAL_HALF:    scope_d = '{bank_mask: BANKS_01, row_top_zero: 2'h0};
      PARTIAL_QUARTER: scope_d = '{bank_mask: BANKS_0,  row_top_zero: 2'h0};
      PARTIAL_EIGHTH:  scope_d = '{bank_mask: BANKS_0,  row_top_zero: 2'h2};
      PARTIAL_SIXTNTH: scope_d = '{bank_mask: BANKS_0,  row_top_zero: 2'h3};
      default:         scope_d = '{bank_mask: BANKS_ALL, row_top_zero: 2'h0};
    endcase
  end

  always_comb begin
    case (ext_in.drive_strength)                                           // RQ20
      DRIVE_HALF:    ohms_d = OHMS_HALF;
      DRIVE_QUARTER: ohms_d = OHMS_QUARTER;
      DRIVE_THREE_Q: ohms_d = OHMS_THREE_Q;
      default:       ohms_d = OHMS_FULL;
    endcase
  end

  // Held until the next load only; deep sleep leaves them alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q   <= '0;
      loaded_q <= 1'b0;
      error_q  <= 1'b0;
    end else if (load_mode) begin
      mode_q   <= mode_in;                                                 // RQ4
      loaded_q <= 1'b1;
      error_q  <= mode_bad;                                                // RQ24
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_q   <= '0;
      scope_q <= '{bank_mask: BANKS_ALL, row_top_zero: 2'h0};
      ohms_q  <= OHMS_FULL;
    end else if (load_ext) begin
      ext_q   <= ext_in;                                                   // RQ16
      scope_q <= scope_d;
      ohms_q  <= ohms_d;
    end
  end

  // ****************************************************************
  // Clock-enable history and deep sleep
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cke_prev_q <= 1'b0;
      deep_q     <= 1'b0;
    end else begin
      cke_prev_q <= pins.cke;
      if (sleep_entry) begin
        deep_q <= 1'b1;
      end else if (sleep_exit) begin
        deep_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Burst column sequencer
  // ****************************************************************
  logic [COL_W-1:0]  start_q;
  logic [BEAT_W-1:0] beat_q;
  logic              write_q;
  logic              page_q;
  logic [COL_W-1:0]  mask_q;
  logic [COL_W-1:0]  len_mask;
  logic              len_page;

  // Set mask bits select the offset inside the aligned block
  always_comb begin
    len_page = 1'b0;
    case (mode_q.burst_len)
      BURST_LEN_2:    len_mask = 9'h001;
      BURST_LEN_4:    len_mask = 9'h003;
      BURST_LEN_8:    len_mask = 9'h007;
      BURST_LEN_PAGE: begin
        len_mask = 9'h1ff;
        len_page = 1'b1;
      end
      default:        len_mask = 9'h000;
    endcase
  end

  // Writes are single-location when the single write bit is set
  wire              single   = cmd_write && mode_q.single_write_bit;       // RQ13
  wire [COL_W-1:0]  new_mask = single ? 9'h000 : len_mask;
  wire              new_page = !single && len_page;

  wire [COL_W-1:0]  cur_start = cmd_access ? pins.addr[COL_W-1:0] : start_q;
  wire [COL_W-1:0]  cur_mask  = cmd_access ? new_mask : mask_q;
  wire              cur_page  = cmd_access ? new_page : page_q;
  wire [COL_W-1:0]  cur_beat  = cmd_access ? 9'h000 : {5'h00, beat_q};

  wire [COL_W-1:0]  seq_col   = cur_start + cur_beat;                      // RQ7
  wire [COL_W-1:0]  ilv_col   = cur_start ^ cur_beat;                      // RQ8
  wire [COL_W-1:0]  in_block  = (mode_q.burst_order_bit == ORDER_SEQ) ? seq_col : ilv_col;
  wire [COL_W-1:0]  fixed_col = (cur_start & ~cur_mask) | (in_block & cur_mask); // RQ6
  wire [COL_W-1:0]  cur_col   = cur_page ? seq_col : fixed_col;            // RQ9

  // A new read or write starts at once and cuts a running burst
  wire              beat_now  = cmd_access || (run_q && !cmd_stop);
  wire              beat_wr   = cmd_access ? cmd_write : write_q;
  wire [BEAT_W-1:0] next_beat = cmd_access ? 4'h1 : beat_q + 4'h1;
  wire              last_beat = !cur_page && (cur_beat == cur_mask);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q   <= 1'b0;
      start_q <= '0;
      mask_q  <= '0;
      page_q  <= 1'b0;
      write_q <= 1'b0;
      beat_q  <= '0;
    end else begin
      run_q   <= beat_now && !last_beat;                                   // RQ9
      start_q <= cur_start;
      mask_q  <= cur_mask;
      page_q  <= cur_page;
      write_q <= beat_wr;
      beat_q  <= next_beat;
    end
  end

  // The beat counter wraps after sixteen beats, so a page burst
  // steps on from the column last shown rather than from the counter;
  // this keeps the walk right for bursts of any length
  logic [COL_W-1:0] page_start_q;
  logic [COL_W-1:0] out_col;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_start_q <= '0;
    end else begin
      page_start_q <= out_col + 9'h001;                                    // RQ9
    end
  end

  assign out_col = (cur_page && !cmd_access) ? page_start_q : cur_col;

  // ****************************************************************
  // Read latency pipeline
  // ****************************************************************
  logic rd_pipe_q;
  logic drive_q;
  logic valid_q;
  logic act_q;
  logic act_wr_q;
  logic [COL_W-1:0] col_q;

  // Latency two drives in the beat's own cycle, three one cycle later;
  // valid always trails drive by one cycle
  wire rd_beat = beat_now && !beat_wr;
  wire lat3    = (mode_q.read_latency == LATENCY_3);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pipe_q <= 1'b0;
      drive_q   <= 1'b0;
      valid_q   <= 1'b0;
    end else begin
      rd_pipe_q <= rd_beat;
      drive_q   <= lat3 ? rd_pipe_q : rd_beat;                             // RQ11
      valid_q   <= drive_q;                                                // RQ11
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_q    <= 1'b0;
      act_wr_q <= 1'b0;
      col_q    <= '0;
    end else begin
      act_q    <= beat_now;                                                // RQ19
      act_wr_q <= beat_wr;
      col_q    <= out_col;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output below is a register of this block
  assign mode_cfg         = mode_q;
  assign ext_cfg          = ext_q;
  assign mode_loaded      = loaded_q;
  assign config_error     = error_q;
  assign refresh_scope    = scope_q;
  assign drive_ohms       = ohms_q;
  assign burst_active     = act_q;
  assign burst_is_write   = act_wr_q;
  assign burst_col        = col_q;
  assign dq_drive_en      = drive_q;
  assign dq_data_valid    = valid_q;
  assign deep_sleep_state = deep_q;

endmodule

// [test/sdmc_ctrl_model.sv]
// Behavioural controller that drives the command and address pins.
// Assumes the bench queues commands with push between clock edges.
`timescale 1ns/10ps
module sdmc_ctrl_model
  import sdmc_pkg::*;
#(
  parameter int SETTLE = 2
) (
  input  wire logic            clk,    // Block clock
  input  wire logic            resetn, // Async reset
  output sdmc_pkg::sdmc_pins_t pins    // Pins to the device
);
  // **********************
  // Command queue
  // **********************
  sdmc_pins_t q[$];
  sdmc_pins_t nxt;
  int         gap;


  function automatic void push(input logic k, input logic [3:0] c, input logic [1:0] b,
                               input logic [12:0] a);
    if (c == CMD_CONFIG_LOAD && b == BANK_SEL_MODE) a[12:10] = 3'h0;
    if (c == CMD_CONFIG_LOAD && b == BANK_SEL_EXT) a[12:7] = 6'h0;
    q.push_back({k, c, b, a});
  endfunction

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins <= {1'b1, 4'hf, 2'h0, 13'h0};
      gap = 0;
    end else if (gap > 0 || q.size() == 0) begin
      // Deselect; released lines toggle
      pins <= {pins.cke, 4'hf, ~pins.ba, ~pins.addr};
      if (gap > 0) gap--;
    end else begin
      nxt = q.pop_front();
      pins <= nxt;
      if (nxt.cmd == CMD_CONFIG_LOAD) gap = SETTLE;
    end
  end
endmodule

// [test/sdmc_core_asserts.sv]
// Port-level checker of the SDRAM configuration block.
// Assumes pins pass two sync flops, so loads show three edges later.
`timescale 1ns/10ps
module sdmc_core_asserts
  import sdmc_pkg::*;
(
  input wire logic              clk,              // Clock
  input wire logic              resetn,           // Reset
  input wire logic              cke,              // Clock enable
  input wire logic              cs_n,             // Select
  input wire logic              ras_n,            // Row strobe
  input wire logic              cas_n,            // Column strobe
  input wire logic              we_n,             // Write enable
  input wire logic [BANK_W-1:0] ba,               // Bank
  input wire logic [ADDR_W-1:0] addr,             // Address
  input sdmc_pkg::sdmc_mode_t   mode_cfg,         // Mode word
  input sdmc_pkg::sdmc_ext_t    ext_cfg,          // Extended word
  input wire logic              mode_loaded,      // Loaded
  input wire logic              config_error,     // Error
  input sdmc_pkg::sdmc_refresh_t refresh_scope,   // Scope
  input wire logic [OHM_W-1:0]  drive_ohms,       // Impedance
  input wire logic              burst_active,     // Beat
  input wire logic              burst_is_write,   // Write beat
  input wire logic [COL_W-1:0]  burst_col,        // Column
  input wire logic              dq_drive_en,      // Driving
  input wire logic              dq_data_valid,    // Valid
  input wire logic              deep_sleep_state  // Sleep
);
  // **********************
  // Checks
  // **********************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  wire logic [3:0] cmd_w = {cs_n, ras_n, cas_n, we_n};
  wire logic [1:0] ds_w = ext_cfg.drive_strength;
  wire logic [2:0] pf_w = ext_cfg.partial_refresh_field;
  wire logic [6:0] ohm_w = ds_w == DRIVE_HALF ? OHMS_HALF : ds_w == DRIVE_QUARTER ?
    OHMS_QUARTER : ds_w == DRIVE_THREE_Q ? OHMS_THREE_Q : OHMS_FULL;
  wire logic [5:0] scope_w = pf_w == PARTIAL_HALF ? {BANKS_01, 2'h0} :
    pf_w == PARTIAL_QUARTER ? {BANKS_0, 2'h0} : pf_w == PARTIAL_EIGHTH ? {BANKS_0, 2'h2} :
    pf_w == PARTIAL_SIXTNTH ? {BANKS_0, 2'h3} : {BANKS_ALL, 2'h0};

  mode_hold_a: assert property ($changed(mode_cfg) |->
    $past(cmd_w, 3) == CMD_CONFIG_LOAD && $past(ba, 3) == BANK_SEL_MODE) else $error("mode word");
  ext_hold_a: assert property ($changed(ext_cfg) |->
    $past(cmd_w, 3) == CMD_CONFIG_LOAD && $past(ba, 3) == BANK_SEL_EXT) else $error("ext word");
  temp_ignore_a: assert property (ext_cfg.temp_comp_refresh_field == 2'h0)
    else $error("temp field");
  drive_map_a: assert property (drive_ohms == ohm_w) else $error("drive ohms");
  scope_map_a: assert property (refresh_scope == scope_w) else $error("scope");
  data_valid_a: assert property (dq_drive_en |=> dq_data_valid) else $error("valid");
  cl2_drive_a: assert property (burst_active && !burst_is_write &&
    mode_cfg.read_latency != LATENCY_3 |-> dq_drive_en) else $error("cl2 drive");
  cl3_drive_a: assert property (burst_active && !burst_is_write &&
    mode_cfg.read_latency == LATENCY_3 |=> dq_drive_en) else $error("cl3 drive");
  single_write_a: assert property ($rose(burst_active) && burst_is_write &&
    mode_cfg.single_write_bit |=> !burst_active) else $error("single write");
  page_step_a: assert property (burst_active && $past(burst_active) &&
    mode_cfg.burst_len == BURST_LEN_PAGE |-> burst_col == $past(burst_col) + 9'h1)
    else $error("page step");
  block_keep_a: assert property (burst_active && $past(burst_active) &&
    mode_cfg.burst_len == BURST_LEN_8 |-> burst_col[8:3] == $past(burst_col[8:3]))
    else $error("block");
  reserved_len_a: assert property (mode_cfg.burst_len inside {3'h4, 3'h5, 3'h6}
    |-> config_error) else $error("reserved");
endmodule

bind sdmc_core sdmc_core_asserts chk_u (.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .mode_cfg(mode_cfg),
  .ext_cfg(ext_cfg), .mode_loaded(mode_loaded), .config_error(config_error),
  .refresh_scope(refresh_scope), .drive_ohms(drive_ohms), .burst_active(burst_active),
  .burst_is_write(burst_is_write), .burst_col(burst_col), .dq_drive_en(dq_drive_en),
  .dq_data_valid(dq_data_valid), .deep_sleep_state(deep_sleep_state));

// [test/sdram_mode_config_tb_top.sv]
// Self-checking bench of the SDRAM configuration block.
// Assumes the controller model and checker compile first.
`timescale 1ns/10ps
module sdram_mode_config_tb_top;
  import sdmc_pkg::*;
  // **********************
  // Signals and model state
  // **********************
  logic             clk, resetn;
  sdmc_pins_t       pins;
  sdmc_mode_t       mode_cfg;
  sdmc_ext_t        ext_cfg;
  sdmc_refresh_t    refresh_scope;
  logic             mode_loaded, config_error, burst_active, burst_is_write;
  logic             dq_drive_en, dq_data_valid, deep_sleep_state;
  logic [OHM_W-1:0] drive_ohms;
  logic [COL_W-1:0] burst_col;
  logic [9:0]       last_w;
  logic [6:0]       last_e;
  int               bad_count, num_checks, m_len, m_lat;
  bit               m_il, m_swb;
  int               ohm_tab[4] = '{25, 55, 80, 37};
  int               scope_tab[8] = '{60, 12, 4, 60, 60, 6, 7, 60};

  sdmc_ctrl_model ctrl_u (.clk(clk), .resetn(resetn), .pins(pins));
  sdmc_core dut_u (.clk(clk), .resetn(resetn), .cke(pins.cke), .cs_n(pins.cmd[3]),
    .ras_n(pins.cmd[2]), .cas_n(pins.cmd[1]), .we_n(pins.cmd[0]), .ba(pins.ba),
    .addr(pins.addr), .mode_cfg(mode_cfg), .ext_cfg(ext_cfg), .mode_loaded(mode_loaded),
    .config_error(config_error), .refresh_scope(refresh_scope), .drive_ohms(drive_ohms),
    .burst_active(burst_active), .burst_is_write(burst_is_write), .burst_col(burst_col),
    .dq_drive_en(dq_drive_en), .dq_data_valid(dq_data_valid),
    .deep_sleep_state(deep_sleep_state));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic load(input logic [1:0] b, input logic [12:0] a);
    ctrl_u.push(1'b1, CMD_CONFIG_LOAD, b, a);
    tick(8);
  endtask

  task automatic set_mode(input int blc, input bit il, input int lat, input bit swb);
    last_w = {swb, 2'b00, 3'(lat), il, 3'(blc)};
    load(BANK_SEL_MODE, {3'h0, last_w});
    m_len = (blc == 7) ? 512 : (blc < 4) ? 1 << blc : 1;
    m_lat = (lat == 3) ? 3 : 2;
    m_il = il;
    m_swb = swb;
    chk(mode_cfg, last_w);
    chk(config_error, blc inside {4, 5, 6} || (blc == 7 && il) || !(lat inside {2, 3}));
    chk(mode_loaded, 1'b1);
  endtask

  function automatic int col_of(input int s, input int i);
    if (m_len > 8) return (s + i) % 512;
    if (m_il) return (s & ~(m_len - 1)) | ((s % m_len) ^ i);
    return (s & ~(m_len - 1)) | ((s + i) % m_len);
  endfunction

  task automatic rw(input bit wr, input int col, input int stop);
    int bl;
    int i;
    int j;
    bl = (wr && m_swb) ? 1 : m_len;
    if (stop > 0) bl = stop;
    ctrl_u.push(1'b1, wr ? CMD_WRITE : CMD_READ, 2'($urandom_range(3, 0)), 13'(col));
    for (int c = 0; c < bl + m_lat + 5; c++) begin
      tick(1);
      if (c == stop - 1) ctrl_u.push(1'b1, CMD_BURST_STOP, 2'h0, 13'h0);
      i = c - 3;
      j = c - 1 - m_lat;
      chk(burst_active, i >= 0 && i < bl);
      if (i >= 0 && i < bl) chk({burst_is_write, burst_col}, {wr, 9'(col_of(col, i))});
      chk(dq_drive_en, !wr && j >= 0 && j < bl);
      chk(dq_data_valid, !wr && j >= 1 && j <= bl);
    end
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    void'($urandom(32'h632f));
    tick(2);
    for (int k = 0; k < 32; k++) begin
      set_mode(k % 4, (k >> 2) & 1, (k >> 3) & 1 ? 3 : 2, k >> 4);
      rw(1'b0, $urandom_range(511, 0), 0);
      rw(1'b1, $urandom_range(511, 0), 0);
    end
    set_mode(4, 0, 2, 0);
    rw(1'b0, $urandom_range(511, 0), 0);
    set_mode(1, 0, 5, 0);
    rw(1'b0, $urandom_range(511, 0), 0);
    set_mode(7, 0, 3, 0);
    rw(1'b0, 510, 5);
    rw(1'b1, 509, 4);
    for (int d = 0; d < 4; d++) begin
      for (int p = 0; p < 8; p++) begin
        load(BANK_SEL_EXT, {6'h0, 2'(d), 2'($urandom_range(3, 0)), 3'(p)});
        last_e = {2'(d), 2'h0, 3'(p)};
        chk(ext_cfg, last_e);
        chk(drive_ohms, ohm_tab[d]);
        chk(refresh_scope, scope_tab[p]);
      end
    end
    load(2'h1, 13'h1fff);
    chk({mode_cfg, ext_cfg}, {last_w, last_e});
    ctrl_u.push(1'b1, 4'h7, 2'h0, 13'h0);
    ctrl_u.push(1'b0, CMD_BURST_STOP, 2'h0, 13'h0);
    tick(8);
    chk(deep_sleep_state, 1'b1);
    ctrl_u.push(1'b1, 4'h7, 2'h0, 13'h0);
    tick(8);
    chk(deep_sleep_state, 1'b0);
    chk(ext_cfg, last_e);
    summarize();
  end
endmodule
